// ---- hw/ptc_cfg.svh ----
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH
// Register word addresses, index = printed offset, byte address = 4 * index
`define PTC_T0_COUNT      8'h50
`define PTC_T0_LIMA       8'h52
`define PTC_T0_LIMB       8'h54
`define PTC_T0_MODE       8'h56
`define PTC_T1_COUNT      8'h58
`define PTC_T1_LIMA       8'h5A
`define PTC_T1_LIMB       8'h5C
`define PTC_T1_MODE       8'h5E
`define PTC_T2_COUNT      8'h60
`define PTC_T2_LIMA       8'h62
`define PTC_T2_MODE       8'h66
// Mode word field positions
`define PTC_B_EN          15
`define PTC_B_GUARD       14
`define PTC_B_INT         13
`define PTC_B_SEL         12
`define PTC_B_MAXF        5
`define PTC_B_RTG         4
`define PTC_B_PRE         3
`define PTC_B_EXT         2
`define PTC_B_DUAL        1
`define PTC_B_CONTINUOUS_RUN        0
// Reset values
`define PTC_RST_WORD      16'h0000
// Internal tick divider: one tick every fourth core clock
`define PTC_TICK_DIV      4
`endif

// ---- hw/ptc_pkg.sv ----
package ptc_pkg;
  typedef struct packed {
    logic [9:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ptc_req_s;
  typedef struct packed {
    logic en;
    logic irq_en;
    logic sel;
    logic maxf;
    logic retrigger_select;
    logic pre;
    logic external_clock_select;
    logic dual;
    logic continuous_run;
  } ptc_mode_s;
endpackage : ptc_pkg

// ---- hw/ptc_timer_top.sv ----
// Functional notes
// [R1] No counting while run enable is zero
// [R2] Pin edges ignored and forgotten while disabled
// [R3] Single run clears enable at limit
// [R4] Enable written only when guard bit set
// [R5] Guard bit unstored, reads zero
// [R6] Interrupt enable gives request per terminal count
// [R7] Dual mode requests at both limits
// [R8] Issued request not withdrawn by disabling
// [R9] Max flag set at every limit hit
// [R10] Software clears max flag by writing zero
// [R11] Select status shows compared limit register
// [R12] Select status unwritable, zero without dual mode
// [R13] Count register readable and writable anytime
// [R14] Count write takes effect immediately
// [R15] Timers 0,1 dual limits; timer 2 single
// [R16] Reset only on equality; otherwise wrap
// [R17] Reset clears every run enable
// [R18] Reset selects limit A, outputs high
// [R19] Output pulse low single, else shows register
// [R20] Continuous runs forever; else A, B, halt
// [R21] External clock edges, or internal gated/retriggered
// [R22] Internal quarter rate, or timer 2 prescale
// [R23] Timer 2 missing mode bits read zero
//
// Strobed register access and the placing of the registers were left to the implementer.
`include "ptc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module ptc_timer_top
  import ptc_pkg::*;
#(
  parameter int NTMR = 3
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              srst_i,
  // Register port
  input  wire ptc_pkg::ptc_req_s req_i,
  output logic [31:0]            rdata_o,
  // Timer pins
  input  wire logic [1:0]        tmr_in_i,
  output logic [1:0]             tmr_out_o,
  // Interrupt requests to interrupt controller
  output logic [NTMR-1:0]        irq_o
);
  import ptc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Tick divider
  logic [1:0] div_q;
  logic       tick;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
  assign tick = (div_q == 2'(`PTC_TICK_DIV - 1)); // [R22]

  //////////////////////////////////////////////////////////////////////////////
  // Address decode, word index from byte address
  logic [7:0] widx;
  assign widx = req_i.addr[9:2];

  logic [15:0] cnt_q   [NTMR];
  logic [15:0] lima_q  [NTMR];
  logic [15:0] limb_q  [NTMR];
  ptc_mode_s   mode_q  [NTMR];
  logic [NTMR-1:0] hit;
  logic [1:0]  in_q;
  logic        t2_hit;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      in_q <= 2'h0;
    end else begin
      in_q <= tmr_in_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-timer logic
  for (genvar t = 0; t < NTMR; t++) begin : g_tmr
    localparam bit FULL = (t < 2);                             // [R15]
    localparam logic [7:0] A_CNT = (t == 0) ? `PTC_T0_COUNT :
                                   (t == 1) ? `PTC_T1_COUNT : `PTC_T2_COUNT;
    localparam logic [7:0] A_LA  = (t == 0) ? `PTC_T0_LIMA :
                                   (t == 1) ? `PTC_T1_LIMA : `PTC_T2_LIMA;
    localparam logic [7:0] A_LB  = (t == 0) ? `PTC_T0_LIMB : `PTC_T1_LIMB;
    localparam logic [7:0] A_MD  = (t == 0) ? `PTC_T0_MODE :
                                   (t == 1) ? `PTC_T1_MODE : `PTC_T2_MODE;
    logic pin;
    logic pin_rise;
    logic armed_q;
    logic adv;
    logic retrig;
    logic [15:0] lim;
    logic wr_cnt;
    logic wr_md;
    logic outp_q;
    logic [1:0] pend_q;

    if (FULL) begin : g_pin
      logic pin_d_q;
      assign pin = in_q[t];
      always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
          pin_d_q <= 1'b0;
        end else begin
          pin_d_q <= pin;
        end
      end
      // Edge only counts while enabled, so nothing is stored across a halt
      assign pin_rise = pin & ~pin_d_q & mode_q[t].en;          // [R2]
    end else begin : g_nopin
      assign pin = 1'b0;
      assign pin_rise = 1'b0;
    end

    assign wr_cnt = req_i.wr && (widx == A_CNT);
    assign wr_md  = req_i.wr && (widx == A_MD);
    assign lim    = (FULL && mode_q[t].sel) ? limb_q[t] : lima_q[t];

    // Retrigger: first edge arms and clears, later edges clear again
    assign retrig = FULL && !mode_q[t].external_clock_select && mode_q[t].retrigger_select && pin_rise; // [R21]
    always_ff @(posedge core_clk_i) begin
      if (srst_i || !mode_q[t].en) begin
        armed_q <= 1'b0;                                        // [R2]
      end else if (retrig) begin
        armed_q <= 1'b1;
      end
    end

    always_comb begin
      adv = 1'b0;
      if (!mode_q[t].en) begin
        adv = 1'b0;                                             // [R1]
      end else if (FULL && mode_q[t].external_clock_select) begin
        adv = pin_rise;                                         // [R21]
      end else if (FULL && mode_q[t].pre) begin
        adv = t2_hit;                                           // [R22]
      end else if (FULL && mode_q[t].retrigger_select) begin
        adv = tick && armed_q;                                  // [R21]
      end else if (FULL) begin
        adv = tick && pin;                                      // [R21]
      end else begin
        adv = tick;                                             // [R22]
      end
    end

    // Equality only; a count above the limit runs on through wrap
    assign hit[t] = adv && !retrig && (cnt_q[t] == lim);       // [R16]

    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        cnt_q[t] <= `PTC_RST_WORD;
      end else if (wr_cnt) begin
        cnt_q[t] <= req_i.wdata;                                // [R13] [R14]
      end else if (retrig || hit[t]) begin
        cnt_q[t] <= 16'h0000;                                   // [R16]
      end else if (adv) begin
        cnt_q[t] <= cnt_q[t] + 16'h0001;
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        lima_q[t] <= `PTC_RST_WORD;
      end else if (req_i.wr && widx == A_LA) begin
        lima_q[t] <= req_i.wdata;
      end
    end
    if (FULL) begin : g_limb
      always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
          limb_q[t] <= `PTC_RST_WORD;
        end else if (req_i.wr && widx == A_LB) begin
          limb_q[t] <= req_i.wdata;
        end
      end
    end else begin : g_nolimb
      always_ff @(posedge core_clk_i) begin
        limb_q[t] <= 16'h0000;                                  // [R15]
      end
    end

    // Mode word; hardware set of the flag wins over software clear
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        mode_q[t] <= '0;                                        // [R17] [R18]
      end else begin
        if (wr_md) begin
          mode_q[t].irq_en <= req_i.wdata[`PTC_B_INT];
          mode_q[t].continuous_run   <= req_i.wdata[`PTC_B_CONTINUOUS_RUN];
          mode_q[t].retrigger_select    <= FULL & req_i.wdata[`PTC_B_RTG];   // [R23]
          mode_q[t].pre    <= FULL & req_i.wdata[`PTC_B_PRE];   // [R23]
          mode_q[t].external_clock_select    <= FULL & req_i.wdata[`PTC_B_EXT];   // [R23]
          mode_q[t].dual   <= FULL & req_i.wdata[`PTC_B_DUAL];  // [R23]
          mode_q[t].maxf   <= req_i.wdata[`PTC_B_MAXF];         // [R10]
          if (req_i.wdata[`PTC_B_GUARD]) begin
            mode_q[t].en <= req_i.wdata[`PTC_B_EN];             // [R4]
          end
        end
        if (hit[t]) begin
          mode_q[t].maxf <= 1'b1;                               // [R9]
          // Without continuous run, single mode halts at each limit; dual halts after limit B
          if (!mode_q[t].continuous_run && (!mode_q[t].dual || mode_q[t].sel)) begin
            mode_q[t].en <= 1'b0;                               // [R3] [R20]
          end
        end
        // Select state is not written by software
        if (!mode_q[t].dual || (wr_md && !(FULL & req_i.wdata[`PTC_B_DUAL]))) begin
          mode_q[t].sel <= 1'b0;                                // [R12]
        end else if (hit[t]) begin
          mode_q[t].sel <= ~mode_q[t].sel;                      // [R11] [R20]
        end
      end
    end

    // Interrupt request pulse; latched downstream, so later disable is harmless
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        irq_o[t] <= 1'b0;
      end else begin
        irq_o[t] <= hit[t] && mode_q[t].irq_en;                 // [R6] [R7] [R8]
      end
    end

    // Output: low for one clock, two clocks after the limit hit, or shows active register
    if (FULL) begin : g_out
      always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
          pend_q <= 2'h0;
          outp_q <= 1'b1;                                       // [R18]
        end else begin
          pend_q <= {pend_q[0], hit[t] && !mode_q[t].dual};
          outp_q <= mode_q[t].dual ? ~mode_q[t].sel : ~pend_q[0]; // [R19]
        end
      end
      assign tmr_out_o[t] = outp_q;
    end else begin : g_noout
      always_ff @(posedge core_clk_i) begin
        pend_q <= 2'h0;
        outp_q <= 1'b1;
      end
    end
  end

  assign t2_hit = hit[NTMR-1];

  //////////////////////////////////////////////////////////////////////////////
  // Read mux, data in the cycle after the strobe
  function automatic logic [15:0] mode_word(input ptc_mode_s m);
    logic [15:0] w;
    w = 16'h0000;
    w[`PTC_B_EN]    = m.en;
    w[`PTC_B_GUARD] = 1'b0;                                     // [R5]
    w[`PTC_B_INT]   = m.irq_en;
    w[`PTC_B_SEL]   = m.sel;                                    // [R11]
    w[`PTC_B_MAXF]  = m.maxf;
    w[`PTC_B_RTG]   = m.retrigger_select;
    w[`PTC_B_PRE]   = m.pre;
    w[`PTC_B_EXT]   = m.external_clock_select;
    w[`PTC_B_DUAL]  = m.dual;
    w[`PTC_B_CONTINUOUS_RUN]  = m.continuous_run;
    return w;
  endfunction : mode_word

  logic [15:0] rd_d;
  always_comb begin
    rd_d = 16'h0000;
    case (widx)
      `PTC_T0_COUNT: rd_d = cnt_q[0];                           // [R13]
      `PTC_T0_LIMA:  rd_d = lima_q[0];
      `PTC_T0_LIMB:  rd_d = limb_q[0];
      `PTC_T0_MODE:  rd_d = mode_word(mode_q[0]);
      `PTC_T1_COUNT: rd_d = cnt_q[1];
      `PTC_T1_LIMA:  rd_d = lima_q[1];
      `PTC_T1_LIMB:  rd_d = limb_q[1];
      `PTC_T1_MODE:  rd_d = mode_word(mode_q[1]);
      `PTC_T2_COUNT: rd_d = cnt_q[2];
      `PTC_T2_LIMA:  rd_d = lima_q[2];
      `PTC_T2_MODE:  rd_d = mode_word(mode_q[2]);
      default:       rd_d = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (req_i.rd) begin
      rdata_o <= {16'h0000, rd_d};
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule : ptc_timer_top
`default_nettype wire

// ---- verif/ptc_irq_latch.sv ----
`timescale 1ns/10ps
`default_nettype none
module ptc_irq_latch (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  // Requests and service
  input  wire logic [2:0] irq_i,
  input  wire logic [2:0] clr_i,
  output logic [2:0]      pend_o
);
  // Held until serviced; the timer's enable bit is never seen here
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pend_o <= 3'h0;
    end else begin
      pend_o <= (pend_o & ~clr_i) | irq_i;
    end
  end
endmodule : ptc_irq_latch
`default_nettype wire

// ---- verif/ptc_timer_chk.sv ----
`include "ptc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module ptc_timer_chk
  import ptc_pkg::*;
#(
  parameter int NTMR = 3
) (
  // Watched ports
  input wire logic              core_clk_i,
  input wire logic              srst_i,
  input wire ptc_pkg::ptc_req_s req_i,
  input wire logic [31:0]       rdata_o,
  input wire logic [1:0]        tmr_in_i,
  input wire logic [1:0]        tmr_out_o,
  input wire logic [NTMR-1:0]   irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////////
  sequence s_mode_rd;
    req_i.rd && (req_i.addr[9:2] inside {`PTC_T0_MODE, `PTC_T1_MODE, `PTC_T2_MODE});
  endsequence
  sequence s_t2_rd;
    req_i.rd && req_i.addr[9:2] == `PTC_T2_MODE;
  endsequence
  // Missing timer 2 limit B and the space above the map
  sequence s_gap_rd;
    req_i.rd && (req_i.addr[9:2] == 8'h64 || req_i.addr[9:2] > 8'h66);
  endsequence
  ////////////////////////////////////////////////////////////////
  a_guard_reads_zero: assert property (s_mode_rd |=> rdata_o[14] == 1'b0)
    else $error("guard bit read as one");
  a_t2_bits_zero: assert property (s_t2_rd |=> rdata_o[4:1] == 4'h0)
    else $error("timer 2 missing mode bits not zero");
  a_sel_needs_dual: assert property (s_mode_rd |=> rdata_o[1] || !rdata_o[12])
    else $error("select status set without dual mode");
  a_gap_read_zero: assert property (s_gap_rd |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_idle_read_zero: assert property (!req_i.rd |=> rdata_o == 32'h0)
    else $error("read data outside read answer");
  a_upper_half_zero: assert property (rdata_o[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_irq_one_pulse: assert property (|irq_o |=> (irq_o & $past(irq_o)) == '0)
    else $error("interrupt request longer than one cycle");
  a_reset_state: assert property (@(posedge core_clk_i) disable iff (1'b0)
    srst_i |=> tmr_out_o == 2'b11 && irq_o == '0)
    else $error("outputs wrong after reset");
endmodule : ptc_timer_chk
bind ptc_timer_top ptc_timer_chk #(.NTMR(NTMR)) u_chk (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .req_i(req_i), .rdata_o(rdata_o),
  .tmr_in_i(tmr_in_i), .tmr_out_o(tmr_out_o), .irq_o(irq_o));
`default_nettype wire

// ---- verif/tb_ptc_timer_top.sv ----
`include "ptc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module tb_ptc_timer_top;
  import ptc_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        srst_i     = 1'b1;
  ptc_req_s    req        = '0;
  logic [31:0] rdata;
  logic [1:0]  tin        = 2'b11;
  logic [1:0]  tout;
  logic [2:0]  irq;
  logic [2:0]  clr        = 3'h0;
  logic [2:0]  pend;
  logic [15:0] r;
  int          n_errors   = 0;
  int          compares   = 0;
  int          cyc        = 0;
  int          n;
  always #25 core_clk_i = ~core_clk_i;
  ptc_timer_top #(.NTMR(3)) dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .req_i(req),
    .rdata_o(rdata), .tmr_in_i(tin), .tmr_out_o(tout), .irq_o(irq));
  ptc_irq_latch u_irq (.core_clk_i(core_clk_i), .srst_i(srst_i), .irq_i(irq),
    .clr_i(clr), .pend_o(pend));
  ////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    req <= '{addr: {a, 2'b00}, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    req <= '0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk_i);
    req <= '{addr: {a, 2'b00}, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    req <= '0;
    #1 `CHK(rdata[15:0], e)
  endtask : rdc
  task automatic wirq(input int i);
    n = 0;
    while (irq[i] !== 1'b1 && n < 300) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    `CHK(irq[i], 1'b1)
  endtask : wirq
  // Pin edges land on a clock edge, as the input flop expects
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge core_clk_i);
      tin[0] <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      tin[0] <= 1'b1;
      repeat (3) @(posedge core_clk_i);
    end
  endtask : pulse
  task automatic fin(input int k);
    $display("test %0d done", k);
  endtask : fin
  task results;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // Whole run needs well under 3000 cycles
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h9d553e0e));
    repeat (12) @(posedge core_clk_i);
    srst_i <= 1'b0;
    #1 `CHK(tout, 2'b11)
    for (int k = 0; k < 3; k++) rdc(8'h56 + 8'(8 * k), 16'h0000);
    fin(1);
    r = 16'($urandom);
    wr(`PTC_T0_COUNT, r);
    wr(`PTC_T0_MODE, 16'h8001);
    repeat (40) @(posedge core_clk_i);
    rdc(`PTC_T0_COUNT, r);
    rdc(`PTC_T0_MODE, 16'h0001);
    wr(`PTC_T0_MODE, 16'hC001);
    rdc(`PTC_T0_MODE, 16'h8001);
    fin(2);
    wr(`PTC_T0_MODE, 16'h4004);
    wr(`PTC_T0_LIMA, 16'h00FF);
    wr(`PTC_T0_COUNT, 16'h0000);
    pulse(3);
    wr(`PTC_T0_MODE, 16'hC005);
    repeat (10) @(posedge core_clk_i);
    rdc(`PTC_T0_COUNT, 16'h0000);
    pulse(2);
    rdc(`PTC_T0_COUNT, 16'h0002);
    fin(3);
    wr(`PTC_T0_MODE, 16'h4000);
    wr(`PTC_T0_COUNT, 16'h0000);
    wr(`PTC_T0_LIMA, 16'h0003);
    wr(`PTC_T0_MODE, 16'hE001);
    wirq(0);
    rdc(`PTC_T0_MODE, 16'hA021);
    wr(`PTC_T0_MODE, 16'h4000);
    `CHK(pend[0], 1'b1)
    rdc(`PTC_T0_MODE, 16'h0000);
    clr <= 3'h1;
    @(posedge core_clk_i);
    clr <= 3'h0;
    fin(4);
    wr(`PTC_T0_COUNT, 16'h0000);
    wr(`PTC_T0_LIMA, 16'h0002);
    wr(`PTC_T0_MODE, 16'hC000);
    // Single limit: output low for exactly one clock per hit
    n = 0;
    repeat (60) begin
      @(posedge core_clk_i);
      #1 if (tout[0] === 1'b0) n++;
    end
    `CHK(n, 1)
    rdc(`PTC_T0_MODE, 16'h0020);
    fin(5);
    wr(`PTC_T1_LIMA, 16'h0001);
    wr(`PTC_T1_LIMB, 16'h0002);
    wr(`PTC_T1_MODE, 16'hE002);
    n = 0;
    repeat (120) begin
      @(posedge core_clk_i);
      #1 if (irq[1] === 1'b1) n++;
    end
    `CHK(n, 2)
    rdc(`PTC_T1_MODE, 16'h2022);
    `CHK(tout[1], 1'b1)
    fin(6);
    wr(`PTC_T0_LIMA, 16'h0001);
    wr(`PTC_T0_COUNT, 16'hFFFE);
    wr(`PTC_T0_MODE, 16'hE001);
    wirq(0);
    `CHK(n >= 8, 1'b1)
    wr(`PTC_T0_MODE, 16'h4000);
    fin(7);
    // Far limit keeps timer 2 from hitting before the read
    wr(`PTC_T2_LIMA, 16'hFFFF);
    wr(`PTC_T2_MODE, 16'hC01F);
    rdc(`PTC_T2_MODE, 16'h8001);
    wr(`PTC_T2_MODE, 16'h4000);
    wr(8'h64, r);
    rdc(8'h64, 16'h0000);
    rdc(`PTC_T1_LIMB, 16'h0002);
    fin(8);
    results();
  end
endmodule : tb_ptc_timer_top
`undef CHK
`default_nettype wire
